// ### logic/rtec_pkg.sv
// ****************************************
// shared constants and types
// ****************************************
package rtec_pkg;

    localparam int RTEC_CNT_W = 16;
    localparam logic [15:0] RTEC_CNT_ZERO = 16'h0000;
    localparam logic [15:0] RTEC_CNT_MAX = 16'hffff;
    localparam logic [15:0] RTEC_CNT_ONE = 16'h0001;
    localparam logic [15:0] RTEC_COUNT_RESET = 16'h0000;
    localparam logic [15:0] RTEC_RELOAD_RESET = 16'h0000;

    // prescaler ratios
    localparam int RTEC_DIV_EIGHT = 8;
    localparam int RTEC_DIV_THIRTY_TWO = 32;
    localparam int RTEC_SUB_DIV = 32;

    // channel numbering: channels from this index up may run two-phase
    localparam int RTEC_CHANNELS = 5;
    localparam int RTEC_TWO_PHASE_FIRST = 2;

    // low two bits of the mode register
    typedef enum logic [1:0] {
        RTEC_MODE_TIMER,
        RTEC_MODE_EVENT,
        RTEC_MODE_ONESHOT,
        RTEC_MODE_PWM
    } rtec_mode_t;

    // timer-mode count source
    typedef enum logic [1:0] {
        RTEC_CLK_UNDIV,
        RTEC_CLK_DIV8,
        RTEC_CLK_DIV32,
        RTEC_CLK_SUB32
    } rtec_clk_t;

    // event-mode count source
    typedef enum logic [1:0] {
        RTEC_EVT_PIN,
        RTEC_EVT_NEIGHBOUR,
        RTEC_EVT_SECOND_B
    } rtec_evt_t;

    typedef struct packed {
        rtec_mode_t mode;
        rtec_clk_t clk_sel;
        rtec_evt_t evt_src;
        logic gate_en;
        logic gate_high;
        logic pulse_en;
        logic edge_fall;
        logic dir_pin;
        logic dir_up;
        logic free_run;
    } rtec_cfg_t;

endpackage

// ### logic/rtec_prescaler.sv
// ****************************************
// count source prescaler
// ****************************************
module rtec_prescaler #(
    parameter int DIV_A = rtec_pkg::RTEC_DIV_EIGHT,
    parameter int DIV_B = rtec_pkg::RTEC_DIV_THIRTY_TWO,
    parameter int DIV_S = rtec_pkg::RTEC_SUB_DIV
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire rtec_pkg::rtec_clk_t clk_sel,
    input wire logic subclk_tick,
    output logic tick
);

    localparam int AW = $clog2(DIV_A);
    localparam int BW = $clog2(DIV_B);
    localparam int SW = $clog2(DIV_S);
    localparam logic [AW-1:0] A_LAST = AW'(DIV_A - 1);
    localparam logic [BW-1:0] B_LAST = BW'(DIV_B - 1);
    localparam logic [SW-1:0] S_LAST = SW'(DIV_S - 1);

    initial begin
        if (DIV_A < 2 || DIV_B < 2 || DIV_S < 2) begin
            $error("rtec_prescaler: ratios must be at least 2");
        end
    end

    logic [AW-1:0] a_cnt_reg, a_cnt_next;
    logic [BW-1:0] b_cnt_reg, b_cnt_next;
    logic [SW-1:0] s_cnt_reg, s_cnt_next;
    logic tick_reg, tick_next;

    // free-running dividers; sub-clock divider advances only on its own ticks
    always_comb begin
        a_cnt_next = (a_cnt_reg == A_LAST) ? '0 : a_cnt_reg + AW'(1);
        b_cnt_next = (b_cnt_reg == B_LAST) ? '0 : b_cnt_reg + BW'(1);
        s_cnt_next = s_cnt_reg;
        if (subclk_tick) begin
            s_cnt_next = (s_cnt_reg == S_LAST) ? '0 : s_cnt_reg + SW'(1);
        end
        unique case (clk_sel)
            rtec_pkg::RTEC_CLK_UNDIV: tick_next = 1'b1;
            rtec_pkg::RTEC_CLK_DIV8: tick_next = (a_cnt_reg == A_LAST);
            rtec_pkg::RTEC_CLK_DIV32: tick_next = (b_cnt_reg == B_LAST);
            rtec_pkg::RTEC_CLK_SUB32: tick_next = subclk_tick && (s_cnt_reg == S_LAST);
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            a_cnt_reg <= '0;
            b_cnt_reg <= '0;
            s_cnt_reg <= '0;
            tick_reg <= 1'b0;
        end else begin
            a_cnt_reg <= a_cnt_next;
            b_cnt_reg <= b_cnt_next;
            s_cnt_reg <= s_cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign tick = tick_reg;

endmodule // rtec_prescaler

// ### logic/rtec_timer_channel.sv
// Functional notes
// - channel holds a 16-bit counter and a 16-bit reload register
// - low two mode bits pick timer, event counter, one-shot or pulse width; one-shot and pulse width codes leave the channel idle here
// - timer mode decrements on undivided, div-8, div-32 or sub-clock div-32
// - timer counts down, reloads on underflow, ratio 1/(n+1)
// - counting runs while count start is 1, halts when cleared
// - timer mode requests an interrupt on every underflow
// - reading the count returns the live counter value in either mode
// - write while halted loads both reload register and counter
// - write while counting loads reload only; counter takes it next reload
// - gate enabled: count input pin level starts and stops timer counting
// - timer mode pulse output inverts the pin on every underflow
// - event mode counts pin pulses, neighbour overflows or second B overflows
// - pin pulses are counted on a software-selected rising or falling edge
// - event direction up or down from software or the output pin level
// - event wrap reloads and continues; up 1/(ffff-n+1), down 1/(n+1)
// - free-run event counting wraps without loading the reload value
// - event mode requests an interrupt on every overflow or underflow
// - event mode pulse output inverts the pin on every wrap unless the pin sets the count direction
// - channels 0,1 single-phase only; channels 2 to 4 also two-phase; two-phase decoding is not built here
module rtec_timer_channel #(
    parameter int CHANNEL_INDEX = 0
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire rtec_pkg::rtec_cfg_t cfg,
    input wire logic count_start,
    input wire logic wr_en,
    input wire logic [15:0] wr_data,
    input wire logic subclk_tick,
    input wire logic count_input_pin,
    input wire logic neighbour_overflow,
    input wire logic second_b_overflow,
    input wire logic pulse_output_pin_in,
    output logic pulse_output_pin_out,
    output logic pulse_output_pin_oe,
    output logic [15:0] count_value,
    output logic [15:0] reload_value,
    output logic irq_req
);

    // ****************************************
    // elaboration checks
    // ****************************************
    // two-phase decoding is not built in this channel; only the index range
    // and its capability are fixed here
    localparam bit TWO_PHASE_CAPABLE = CHANNEL_INDEX >= rtec_pkg::RTEC_TWO_PHASE_FIRST;

    initial begin
        if (CHANNEL_INDEX < 0 || CHANNEL_INDEX >= rtec_pkg::RTEC_CHANNELS) begin
            $error("rtec_timer_channel: channel index out of range");
        end
    end

    // ****************************************
    // state
    // ****************************************
    logic [15:0] counter_reg, counter_next;
    logic [15:0] reload_reg, reload_next;
    logic pin_prev_reg, pin_prev_next;
    logic start_prev_reg, start_prev_next;
    logic pulse_reg, pulse_next;
    logic oe_reg, oe_next;
    logic irq_reg, irq_next;

    logic presc_tick;
    logic timer_mode;
    logic event_mode;
    logic gate_open;
    logic pin_edge;
    logic evt_tick;
    logic up_sel;
    logic counting_up;
    logic tick_eff;
    logic wrap_now;
    logic start_rise;

    // ****************************************
    // count source selection
    // ****************************************
    rtec_prescaler u_presc (
        .mclk(mclk),
        .rst_n(rst_n),
        .clk_sel(cfg.clk_sel),
        .subclk_tick(subclk_tick),
        .tick(presc_tick)
    );

    // one-shot and pulse width codes leave the channel idle here
    assign timer_mode = cfg.mode == rtec_pkg::RTEC_MODE_TIMER;
    assign event_mode = cfg.mode == rtec_pkg::RTEC_MODE_EVENT;

    // gate level is selectable so either pin polarity can hold the count
    assign gate_open = !cfg.gate_en || (count_input_pin == cfg.gate_high);

    // edge seen against last cycle's sample; pin is synchronous already
    assign pin_edge = cfg.edge_fall ? (pin_prev_reg && !count_input_pin)
                                    : (!pin_prev_reg && count_input_pin);

    // event source mux
    always_comb begin
        unique case (cfg.evt_src)
            rtec_pkg::RTEC_EVT_PIN: evt_tick = pin_edge;
            rtec_pkg::RTEC_EVT_NEIGHBOUR: evt_tick = neighbour_overflow;
            rtec_pkg::RTEC_EVT_SECOND_B: evt_tick = second_b_overflow;
            default: evt_tick = 1'b0;
        endcase
    end

    // direction from pin reuses the output pin as an input
    assign up_sel = cfg.dir_pin ? pulse_output_pin_in : cfg.dir_up;
    assign counting_up = event_mode && up_sel;

    // one count step this cycle
    assign tick_eff = count_start && ((timer_mode && gate_open && presc_tick)
                                      || (event_mode && evt_tick));

    // wrap at the far end of the count direction
    assign wrap_now = tick_eff && (counting_up ? (counter_reg == rtec_pkg::RTEC_CNT_MAX)
                                               : (counter_reg == rtec_pkg::RTEC_CNT_ZERO));

    assign start_rise = count_start && !start_prev_reg;

    // ****************************************
    // next-state logic
    // ****************************************
    // a run-time write and a reload in the same cycle: the counter takes
    // the old reload value, the new one waits for the following reload
    always_comb begin
        counter_next = counter_reg;
        reload_next = reload_reg;
        pulse_next = pulse_reg;
        irq_next = wrap_now;
        pin_prev_next = count_input_pin;
        start_prev_next = count_start;
        oe_next = cfg.pulse_en && (timer_mode || (event_mode && !cfg.dir_pin));
        if (tick_eff) begin
            if (wrap_now) begin
                if (event_mode && cfg.free_run) begin
                    counter_next = counting_up ? rtec_pkg::RTEC_CNT_ZERO
                                               : rtec_pkg::RTEC_CNT_MAX;
                end else begin
                    counter_next = reload_reg;
                end
            end else if (counting_up) begin
                counter_next = counter_reg + rtec_pkg::RTEC_CNT_ONE;
            end else begin
                counter_next = counter_reg - rtec_pkg::RTEC_CNT_ONE;
            end
        end
        if (wr_en) begin
            reload_next = wr_data;
            if (!count_start) begin
                counter_next = wr_data;
            end
        end
        // restart forces a known phase before the first toggle
        if (start_rise && cfg.pulse_en) begin
            pulse_next = 1'b0;
        end else if (wrap_now && cfg.pulse_en) begin
            pulse_next = !pulse_reg;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            counter_reg <= rtec_pkg::RTEC_COUNT_RESET;
            reload_reg <= rtec_pkg::RTEC_RELOAD_RESET;
            pin_prev_reg <= 1'b0;
            start_prev_reg <= 1'b0;
            pulse_reg <= 1'b0;
            oe_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            counter_reg <= counter_next;
            reload_reg <= reload_next;
            pin_prev_reg <= pin_prev_next;
            start_prev_reg <= start_prev_next;
            pulse_reg <= pulse_next;
            oe_reg <= oe_next;
            irq_reg <= irq_next;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign count_value = counter_reg;
    assign reload_value = reload_reg;
    assign pulse_output_pin_out = pulse_reg;
    assign pulse_output_pin_oe = oe_reg;
    assign irq_req = irq_reg;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    chk_halt_holds: assert property (
        !count_start && !wr_en |=> $stable(counter_reg))
        else $error("counter moved while halted");

    chk_halt_write: assert property (
        wr_en && !count_start
        |=> counter_reg == $past(wr_data) && reload_reg == $past(wr_data))
        else $error("halted write did not load both registers");

    chk_run_write: assert property (
        wr_en && count_start && !tick_eff
        |=> reload_reg == $past(wr_data) && $stable(counter_reg))
        else $error("running write touched the counter");

    chk_timer_down: assert property (
        timer_mode && tick_eff && !wrap_now && !wr_en
        |=> counter_reg == $past(counter_reg) - rtec_pkg::RTEC_CNT_ONE)
        else $error("timer did not decrement");

    chk_under_reload: assert property (
        timer_mode && wrap_now && !(wr_en && !count_start)
        |=> counter_reg == $past(reload_reg) && irq_req ##1 !irq_req || wrap_now)
        else $error("underflow reload or interrupt wrong");

    chk_free_wrap: assert property (
        event_mode && cfg.free_run && counting_up && wrap_now && !wr_en
        |=> counter_reg == rtec_pkg::RTEC_CNT_ZERO)
        else $error("free-run overflow did not wrap to zero");

    chk_event_step: assert property (
        event_mode && tick_eff && !wrap_now && !wr_en && counting_up
        |=> counter_reg == $past(counter_reg) + rtec_pkg::RTEC_CNT_ONE)
        else $error("event up count wrong");

    chk_pulse_toggle: assert property (
        wrap_now && cfg.pulse_en && !start_rise
        |=> pulse_output_pin_out != $past(pulse_output_pin_out))
        else $error("pulse output did not invert on wrap");

    chk_pulse_start: assert property (
        start_rise && cfg.pulse_en |=> !pulse_output_pin_out)
        else $error("pulse output not low after start");

    chk_gate_block: assert property (
        timer_mode && cfg.gate_en && count_input_pin != cfg.gate_high && !wr_en
        |=> $stable(counter_reg))
        else $error("gate closed but counter moved");

    chk_irq_cause: assert property (
        irq_req |-> $past(wrap_now))
        else $error("interrupt without wrap");

    // ****************************************
    // assertions: event side, sources, pins, reload register and gate
    // ****************************************
    chk_event_down: assert property (
        event_mode && tick_eff && !wrap_now && !counting_up
        |=> counter_reg == $past(counter_reg) - rtec_pkg::RTEC_CNT_ONE)
        else $error("event down count wrong");

    chk_event_reload: assert property (
        event_mode && !cfg.free_run && wrap_now
        |=> counter_reg == $past(reload_reg))
        else $error("event wrap did not reload");

    chk_free_under: assert property (
        event_mode && cfg.free_run && !counting_up && wrap_now
        |=> counter_reg == rtec_pkg::RTEC_CNT_MAX)
        else $error("free-run underflow did not wrap to ffff");

    chk_wrap_irq: assert property (
        event_mode && wrap_now
        |=> irq_req)
        else $error("no interrupt on event wrap");

    chk_idle_modes: assert property (
        !timer_mode && !event_mode && !wr_en
        |=> $stable(counter_reg))
        else $error("counter moved in an unbuilt mode");

    chk_neighbour_only: assert property (
        event_mode && cfg.evt_src == rtec_pkg::RTEC_EVT_NEIGHBOUR
        && !neighbour_overflow && !wr_en |=> $stable(counter_reg))
        else $error("counted without a neighbour overflow");

    chk_second_only: assert property (
        event_mode && cfg.evt_src == rtec_pkg::RTEC_EVT_SECOND_B
        && !second_b_overflow && !wr_en |=> $stable(counter_reg))
        else $error("counted without a second timer overflow");

    chk_rise_only: assert property (
        event_mode && cfg.evt_src == rtec_pkg::RTEC_EVT_PIN && !cfg.edge_fall
        && !(count_input_pin && !pin_prev_reg) && !wr_en |=> $stable(counter_reg))
        else $error("counted without a rising edge");

    chk_fall_only: assert property (
        event_mode && cfg.evt_src == rtec_pkg::RTEC_EVT_PIN && cfg.edge_fall
        && !(pin_prev_reg && !count_input_pin) && !wr_en |=> $stable(counter_reg))
        else $error("counted without a falling edge");

    chk_dir_pin_up: assert property (
        event_mode && cfg.dir_pin && pulse_output_pin_in && tick_eff && !wrap_now
        |=> counter_reg == $past(counter_reg) + rtec_pkg::RTEC_CNT_ONE)
        else $error("direction pin high but not counting up");

    chk_dir_pin_oe: assert property (
        event_mode && cfg.dir_pin
        |=> !pulse_output_pin_oe)
        else $error("output pin driven while used as direction input");

    chk_timer_oe: assert property (
        timer_mode && cfg.pulse_en
        |=> pulse_output_pin_oe)
        else $error("pulse output enabled but pin not driven");

    chk_pulse_hold: assert property (
        !(cfg.pulse_en && (wrap_now || start_rise))
        |=> $stable(pulse_output_pin_out))
        else $error("pulse output moved without a wrap");

    chk_reload_hold: assert property (
        !wr_en
        |=> $stable(reload_reg))
        else $error("reload register moved without a write");

    chk_run_reload: assert property (
        wr_en && count_start
        |=> reload_reg == $past(wr_data))
        else $error("running write missed the reload register");

    chk_undiv_tick: assert property (
        cfg.clk_sel == rtec_pkg::RTEC_CLK_UNDIV
        |=> presc_tick)
        else $error("undivided source missed a tick");

    chk_gate_run: assert property (
        timer_mode && count_start && cfg.gate_en && count_input_pin == cfg.gate_high
        && presc_tick && !wrap_now
        |=> counter_reg == $past(counter_reg) - rtec_pkg::RTEC_CNT_ONE)
        else $error("gate open but timer did not count");

    cov_timer_under: cover property (timer_mode && wrap_now);
    cov_event_over: cover property (event_mode && counting_up && wrap_now);
    cov_run_write: cover property (wr_en && count_start ##[1:50] wrap_now);
    cov_gate_pause: cover property (timer_mode && cfg.gate_en && count_start && !gate_open);
    cov_dir_pin: cover property (event_mode && cfg.dir_pin && tick_eff);

endmodule // rtec_timer_channel

// ### testbench/rtec_pin_partner.sv
// ****************************************
// pin-side partner: pulse source and pin load
// ****************************************
module rtec_pin_partner (
    input wire logic mclk,
    input wire logic pin_drive,
    input wire logic pin_oe,
    output logic count_input_pin,
    output logic pulse_output_pin_in
);
    timeunit 1ns;
    timeprecision 100ps;

    logic dir_level;

    // pin follows the channel while it drives, else our direction level
    assign pulse_output_pin_in = pin_oe ? pin_drive : dir_level;

    initial begin
        count_input_pin = 1'b0;
        dir_level = 1'b0;
    end

    // change just after an edge, then hold for whole cycles
    task automatic set_pin(input logic lvl, input int hold);
        count_input_pin = lvl;
        repeat (hold) @(posedge mclk);
        #1;
    endtask

    // hold 1 is a prompt source, larger holds a slow one
    task automatic pulse(input int n, input int hold);
        logic idle;
        idle = count_input_pin;
        repeat (n) begin
            set_pin(!idle, hold);
            set_pin(idle, hold);
        end
    endtask

    task automatic set_dir(input logic up);
        dir_level = up;
    endtask
endmodule // rtec_pin_partner

// ### testbench/rtec_timer_channel_tb_top.sv
// ****************************************
// channel testbench
// ****************************************
module rtec_timer_channel_tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    logic mclk, rst_n, count_start, wr_en, subclk_tick, neighbour_overflow, second_b_overflow;
    logic count_input_pin, pulse_output_pin_in, pulse_output_pin_out, pulse_output_pin_oe;
    logic irq_req, pin_was;
    logic [15:0] wr_data, count_value, reload_value, v;
    rtec_pkg::rtec_cfg_t cfg;
    int err_total, checks, irq_cnt, gap, c;

    rtec_timer_channel #(.CHANNEL_INDEX(0)) DUT (.mclk(mclk), .rst_n(rst_n), .cfg(cfg),
        .count_start(count_start), .wr_en(wr_en), .wr_data(wr_data), .subclk_tick(subclk_tick),
        .count_input_pin(count_input_pin), .neighbour_overflow(neighbour_overflow),
        .second_b_overflow(second_b_overflow), .pulse_output_pin_in(pulse_output_pin_in),
        .pulse_output_pin_out(pulse_output_pin_out), .pulse_output_pin_oe(pulse_output_pin_oe),
        .count_value(count_value), .reload_value(reload_value), .irq_req(irq_req));

    rtec_pin_partner u_partner (.mclk(mclk), .pin_drive(pulse_output_pin_out),
        .pin_oe(pulse_output_pin_oe), .count_input_pin(count_input_pin),
        .pulse_output_pin_in(pulse_output_pin_in));

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // sub-clock tick every second cycle keeps the sub32 run short
    always @(posedge mclk) subclk_tick <= ~subclk_tick;
    always @(posedge mclk) if (irq_req === 1'b1) irq_cnt++;

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic step(input int n = 1);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic chk16(input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic chk1(input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic wr(input logic [15:0] d);
        wr_en = 1'b1;
        wr_data = d;
        step();
        wr_en = 1'b0;
    endtask

    // restart from a halted load so each scenario starts from a known count
    task automatic load_run(input logic [15:0] d);
        count_start = 1'b0;
        step();
        wr(d);
        count_start = 1'b1;
    endtask

    task automatic wait_irq;
        for (int i = 0; i < 400; i++) begin
            if (irq_req === 1'b1) return;
            step();
        end
        chk1(1'b1, irq_req);
    endtask

    task automatic irq_gap;
        wait_irq();
        step();
        gap = 1;
        while (irq_req !== 1'b1 && gap < 400) begin
            step();
            gap++;
        end
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_timer;
        cfg = '0;
        cfg.pulse_en = 1'b1;
        wr(16'h0002);
        chk16(16'h0002, count_value);
        chk16(16'h0002, reload_value);
        count_start = 1'b1;
        step();
        chk1(1'b0, pulse_output_pin_out);
        irq_gap();
        chk16(16'h0003, 16'(gap));
        chk16(16'h0002, count_value);
        pin_was = pulse_output_pin_out;
        irq_gap();
        chk1(~pin_was, pulse_output_pin_out);
        wr(16'h0005);
        chk16(16'h0001, count_value);
        chk16(16'h0005, reload_value);
        wait_irq();
        chk16(16'h0005, count_value);
        irq_gap();
        chk16(16'h0006, 16'(gap));
        if (pulse_output_pin_out !== 1'b1) irq_gap();
        count_start = 1'b0;
        step(2);
        v = count_value;
        step(10);
        chk16(v, count_value);
        chk1(1'b1, pulse_output_pin_out);
        count_start = 1'b1;
        step();
        chk1(1'b0, pulse_output_pin_out);
    endtask

    task automatic t_prescale;
        int exp_gap[4] = '{2, 16, 64, 128};
        cfg.pulse_en = 1'b0;
        for (int k = 0; k < 4; k++) begin
            cfg.clk_sel = rtec_pkg::rtec_clk_t'(k[1:0]);
            load_run(16'h0001);
            irq_gap();
            irq_gap();
            chk16(16'(exp_gap[k]), 16'(gap));
        end
    endtask

    task automatic t_gate;
        cfg.clk_sel = rtec_pkg::RTEC_CLK_UNDIV;
        cfg.gate_en = 1'b1;
        cfg.gate_high = 1'b1;
        u_partner.set_pin(1'b0, 1);
        load_run(16'h0020);
        step(5);
        chk16(16'h0020, count_value);
        wr(16'h0030);
        chk16(16'h0020, count_value);
        chk16(16'h0030, reload_value);
        u_partner.set_pin(1'b1, 3);
        v = count_value;
        step(3);
        chk16(v - 16'h0003, count_value);
        u_partner.set_pin(1'b0, 3);
        v = count_value;
        step(3);
        chk16(v, count_value);
        cfg.gate_high = 1'b0;
        v = count_value;
        step(3);
        chk16(v - 16'h0003, count_value);
        cfg.gate_en = 1'b0;
    endtask

    task automatic t_event;
        cfg.mode = rtec_pkg::RTEC_MODE_EVENT;
        cfg.pulse_en = 1'b1;
        cfg.dir_up = 1'b1;
        for (int e = 0; e < 2; e++) begin
            count_start = 1'b0;
            u_partner.set_pin(e[0], 2);
            cfg.edge_fall = e[0];
            load_run(16'hfffd);
            step(2);
            pin_was = pulse_output_pin_out;
            c = irq_cnt;
            u_partner.set_pin(~e[0], 3);
            chk16(16'hfffe, count_value);
            u_partner.set_pin(e[0], 3);
            chk16(16'hfffe, count_value);
            u_partner.pulse(2, 1 + e);
            step(3);
            chk16(16'hfffd, count_value);
            chk16(16'(c + 1), 16'(irq_cnt));
            chk1(~pin_was, pulse_output_pin_out);
        end
        cfg.dir_up = 1'b0;
        load_run(16'h0001);
        u_partner.pulse(2, 1);
        step(3);
        chk16(16'h0001, count_value);
        cfg.free_run = 1'b1;
        load_run(16'h0000);
        u_partner.pulse(1, 1);
        step(3);
        chk16(16'hffff, count_value);
        cfg.dir_up = 1'b1;
        load_run(16'hfffe);
        u_partner.pulse(2, 1);
        step(3);
        chk16(16'h0000, count_value);
        cfg.free_run = 1'b0;
    endtask

    task automatic t_sources;
        cfg.evt_src = rtec_pkg::RTEC_EVT_NEIGHBOUR;
        load_run(16'h0010);
        u_partner.pulse(1, 1);
        step(3);
        chk16(16'h0010, count_value);
        neighbour_overflow = 1'b1;
        step();
        neighbour_overflow = 1'b0;
        step(2);
        chk16(16'h0011, count_value);
        cfg.evt_src = rtec_pkg::RTEC_EVT_SECOND_B;
        second_b_overflow = 1'b1;
        step();
        second_b_overflow = 1'b0;
        step(2);
        chk16(16'h0012, count_value);
        cfg.evt_src = rtec_pkg::RTEC_EVT_PIN;
        cfg.dir_pin = 1'b1;
        u_partner.set_dir(1'b1);
        load_run(16'h0010);
        u_partner.pulse(1, 1);
        step(3);
        chk16(16'h0011, count_value);
        chk1(1'b0, pulse_output_pin_oe);
        u_partner.set_dir(1'b0);
        u_partner.pulse(2, 2);
        step(3);
        chk16(16'h000f, count_value);
        for (int m = 2; m < 4; m++) begin
            cfg.mode = rtec_pkg::rtec_mode_t'(m[1:0]);
            u_partner.pulse(1, 1);
            chk16(16'h000f, count_value);
        end
    endtask

    task automatic give_verdict;
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    initial begin
        rst_n = 1'b0;
        cfg = '0;
        count_start = 1'b0;
        wr_en = 1'b0;
        wr_data = 16'h0000;
        subclk_tick = 1'b0;
        neighbour_overflow = 1'b0;
        second_b_overflow = 1'b0;
        step(10);
        chk16(16'h0000, count_value);
        rst_n = 1'b1;
        step(2);
        t_timer();
        t_prescale();
        t_gate();
        t_event();
        t_sources();
        give_verdict();
    end

    // whole run needs about a thousand cycles
    initial begin
        repeat (30000) @(posedge mclk);
        err_total++;
        give_verdict();
    end
endmodule // rtec_timer_channel_tb_top
